// ### design/pwrsw_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PWRSW_REGS_SVH
`define PWRSW_REGS_SVH

// ----------------------------------------------------------------------
// Register indices as printed, byte address is four times the index
// ----------------------------------------------------------------------
`define PWRSW_IDX_RANDOM_VALUE 16'h6105
`define PWRSW_IDX_SWITCH_CTRL 16'h6106
`define PWRSW_IDX_IRQ_STATUS 16'h6107
`define PWRSW_IDX_IRQ_MASK 16'h6108
`define PWRSW_IDX_POWER_CTRL 16'h6109
`define PWRSW_ADDR_W 18

// ----------------------------------------------------------------------
// Switch and random control fields
// ----------------------------------------------------------------------
`define PWRSW_B_HIDE_SIG 6
`define PWRSW_B_OVERLOAD 5
`define PWRSW_B_SWITCH_EN 4
`define PWRSW_B_CURLIM_OFF 3
`define PWRSW_B_FORCE_RNG 2
`define PWRSW_B_RNG_READY 1
`define PWRSW_CTRL_RESET 8'h41
`define PWRSW_CTRL_WMASK 8'h1e

// ----------------------------------------------------------------------
// Interrupt status bits and power control
// ----------------------------------------------------------------------
`define PWRSW_IRQ_RNG 0
`define PWRSW_IRQ_OVERLOAD 1
`define PWRSW_IRQ_WAKE 2
`define PWRSW_IRQ_W 3
`define PWRSW_B_SOFT_PD 0
`define PWRSW_B_WAKE_EN 1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PWRSW_CLK_MHZ 100
`define PWRSW_RNG_NS 80
`define PWRSW_RNG_CYC ((`PWRSW_RNG_NS * `PWRSW_CLK_MHZ + 999) / 1000)
`define PWRSW_SYNC_NS 20
`define PWRSW_SYNC_CYC ((`PWRSW_SYNC_NS * `PWRSW_CLK_MHZ + 999) / 1000)

`endif

// ### design/pwrsw_pkg.sv
// Types shared by the power switch and random control block
package pwrsw_pkg;
  typedef struct packed {
    logic switch_en;
    logic curlim_off;
    logic force_rng;
    logic hide_sig;
  } pwrsw_ctrl_t;

  typedef struct packed {
    logic sig_in;
    logic aux_pin;
  } pwrsw_pads_t;

  typedef enum logic [1:0] {
    PWRSW_ST_RESET = 2'b00,
    PWRSW_ST_RUN = 2'b01,
    PWRSW_ST_IDLE = 2'b10
  } pwrsw_state_t;
endpackage

// ### design/pwrsw_rng.sv
// Random byte generator with run control and ready strobe
`timescale 1ns/1ns
`default_nettype none
`include "pwrsw_regs.svh"
module pwrsw_rng
  import pwrsw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic [7:0] value,
  output logic fresh
);
  localparam logic [3:0] RNG_CYC = 4'(`PWRSW_RNG_CYC);
  logic [15:0] lfsr_q, lfsr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] value_q, value_d;
  logic fresh_q, fresh_d;

  // --------------------------------------------------------------------
  // LFSR steps only while run is high, one byte sampled per period
  // --------------------------------------------------------------------
  always_comb begin
    lfsr_d = lfsr_q;
    cnt_d = cnt_q;
    value_d = value_q;
    fresh_d = 1'b0;
    if (run) begin
      lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (cnt_q == RNG_CYC - 4'h1) begin
        cnt_d = 4'h0;
        value_d = lfsr_q[7:0];
        fresh_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= 16'hace1;
      cnt_q <= 4'h0;
      value_q <= 8'h00;
      fresh_q <= 1'b0;
    end else begin
      lfsr_q <= lfsr_d;
      cnt_q <= cnt_d;
      value_q <= value_d;
      fresh_q <= fresh_d;
    end
  end

  assign value = value_q;
  assign fresh = fresh_q;
endmodule
`default_nettype wire

// ### design/pwrsw_top.sv
// Secure supply switch, random control register and AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "pwrsw_regs.svh"
module pwrsw_top
  import pwrsw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hard_powerdown_n,
  input wire logic por_ok,
  input wire logic [`PWRSW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PWRSW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic secure_sig_in,
  input wire logic aux_port_pin,
  input wire logic limiter_active,
  input wire logic contactless_rng_run,
  input wire logic wake_event,
  output logic secure_sig_int,
  output logic aux_port_int,
  output logic secure_supply_en,
  output logic inrush_limit_en,
  output logic current_sources_en,
  output logic core_idle,
  output logic irq
);
  // ----------------------------------------------------------------------
  // Local reset: bus reset, hard power-down and power-on reset combined
  // ----------------------------------------------------------------------
  // Pins are synchronised; the local reset therefore lags a pin by two cycles
  logic hpd_s1_q, hpd_s2_q, por_s1_q, por_s2_q;
  logic rst_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hpd_s1_q <= 1'b0;
      hpd_s2_q <= 1'b0;
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
    end else begin
      hpd_s1_q <= hard_powerdown_n;
      hpd_s2_q <= hpd_s1_q;
      por_s1_q <= por_ok;
      por_s2_q <= por_s1_q;
    end
  end
  assign rst_n = aresetn & hpd_s2_q & por_s2_q;

  // ----------------------------------------------------------------------
  // Pad synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pad_s1_q, pad_s2_q;
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      pad_s1_q <= 3'b000;
      pad_s2_q <= 3'b000;
    end else begin
      pad_s1_q <= {secure_sig_in, aux_port_pin, limiter_active};
      pad_s2_q <= pad_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pwrsw_state_t st_q, st_d;
  pwrsw_ctrl_t ctrl_q, ctrl_d;
  logic rdy_q, rdy_d;
  logic [`PWRSW_IRQ_W-1:0] ists_q, ists_d, imask_q, imask_d;
  logic wake_en_q, wake_en_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [`PWRSW_ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rng_run;
  logic [7:0] rng_value;
  logic rng_fresh;
  logic overload;
  logic [7:0] ctrl_rd;
  logic wr_go, rd_go, rd_rng;
  logic [15:0] widx, ridx;

  assign overload = pad_s2_q[0];
  assign rng_run = ctrl_q.force_rng | contactless_rng_run;

  pwrsw_rng u_rng (
    .aclk(aclk),
    .aresetn(rst_n),
    .run(rng_run),
    .value(rng_value),
    .fresh(rng_fresh)
  );

  // Read-only bit 0 reads one, bit 7 zero
  assign ctrl_rd = {1'b0, ctrl_q.hide_sig, overload, ctrl_q.switch_en,
                    ctrl_q.curlim_off, ctrl_q.force_rng, rdy_q, 1'b1};

  assign widx = awa_q[17:2];
  assign ridx = s_axi_araddr[17:2];
  assign wr_go = aw_q & w_q & ~b_q;
  assign rd_go = s_axi_arvalid & ~r_q;
  assign rd_rng = rd_go && ridx == `PWRSW_IDX_RANDOM_VALUE;

  // ----------------------------------------------------------------------
  // AXI4-Lite channels
  // ----------------------------------------------------------------------
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bresp_d = bresp_q;
    r_d = r_q;
    rd_d = rd_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = 2'b00;
      if (widx != `PWRSW_IDX_SWITCH_CTRL && widx != `PWRSW_IDX_IRQ_STATUS &&
          widx != `PWRSW_IDX_IRQ_MASK && widx != `PWRSW_IDX_POWER_CTRL &&
          widx != `PWRSW_IDX_RANDOM_VALUE) begin
        bresp_d = 2'b10;
      end
    end else if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (rd_go) begin
      r_d = 1'b1;
      rresp_d = 2'b00;
      case (ridx)
        `PWRSW_IDX_RANDOM_VALUE: rd_d = {24'h00_0000, rng_value};
        `PWRSW_IDX_SWITCH_CTRL: rd_d = {24'h00_0000, ctrl_rd};
        `PWRSW_IDX_IRQ_STATUS: rd_d = {29'h0000_0000, ists_q};
        `PWRSW_IDX_IRQ_MASK: rd_d = {29'h0000_0000, imask_q};
        `PWRSW_IDX_POWER_CTRL: rd_d = {30'h0000_0000, wake_en_q, st_q == PWRSW_ST_IDLE};
        default: begin
          rd_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control, status, interrupt and power state
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    rdy_d = rdy_q;
    imask_d = imask_q;
    wake_en_d = wake_en_q;
    st_d = st_q;
    ists_d = ists_q;
    if (wr_go && ws_q[0]) begin
      case (widx)
        `PWRSW_IDX_SWITCH_CTRL: begin
          // Only writable bits are taken
          ctrl_d.hide_sig = wd_q[`PWRSW_B_HIDE_SIG];
          ctrl_d.switch_en = wd_q[`PWRSW_B_SWITCH_EN];
          ctrl_d.curlim_off = wd_q[`PWRSW_B_CURLIM_OFF];
          ctrl_d.force_rng = wd_q[`PWRSW_B_FORCE_RNG];
          if (!wd_q[`PWRSW_B_RNG_READY]) begin
            rdy_d = 1'b0;
          end
        end
        `PWRSW_IDX_IRQ_STATUS: ists_d = ists_q & ~wd_q[`PWRSW_IRQ_W-1:0];
        `PWRSW_IDX_IRQ_MASK: imask_d = wd_q[`PWRSW_IRQ_W-1:0];
        `PWRSW_IDX_POWER_CTRL: begin
          wake_en_d = wd_q[`PWRSW_B_WAKE_EN];
          if (wd_q[`PWRSW_B_SOFT_PD]) begin
            st_d = PWRSW_ST_IDLE;
          end
        end
        default: ists_d = ists_q;
      endcase
    end
    if (rd_rng) begin
      rdy_d = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (rng_fresh) begin
      rdy_d = 1'b1;
      ists_d[`PWRSW_IRQ_RNG] = 1'b1;
    end
    if (overload) begin
      ists_d[`PWRSW_IRQ_OVERLOAD] = 1'b1;
    end
    case (st_q)
      PWRSW_ST_RESET: st_d = PWRSW_ST_RUN;
      PWRSW_ST_RUN: st_d = st_d;
      PWRSW_ST_IDLE: begin
        if (wake_en_q && wake_event) begin
          st_d = PWRSW_ST_RUN;
          ists_d[`PWRSW_IRQ_WAKE] = 1'b1;
        end
      end
      default: st_d = PWRSW_ST_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      st_q <= PWRSW_ST_RESET;
      ctrl_q <= '{switch_en: 1'b0, curlim_off: 1'b0, force_rng: 1'b0, hide_sig: 1'b1};
      rdy_q <= 1'b0;
      ists_q <= '0;
      imask_q <= '0;
      wake_en_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      rd_q <= 32'h0000_0000;
      bresp_q <= 2'b00;
      rresp_q <= 2'b00;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      rdy_q <= rdy_d;
      ists_q <= ists_d;
      imask_q <= imask_d;
      wake_en_q <= wake_en_d;
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~aw_q;
  assign s_axi_wready = ~w_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  assign secure_sig_int = ctrl_q.hide_sig ? 1'b0 : pad_s2_q[2];
  assign aux_port_int = ctrl_q.hide_sig ? 1'b1 : pad_s2_q[1];
  assign secure_supply_en = ctrl_q.switch_en;
  assign inrush_limit_en = ~ctrl_q.curlim_off;
  assign current_sources_en = hpd_s2_q;
  assign core_idle = st_q == PWRSW_ST_IDLE;
  assign irq = |(ists_q & imask_q);
endmodule
`default_nettype wire

// ### test/pwrsw_assertions.sv
// Port-level checks for the power switch and random control block
`timescale 1ns/1ns
`default_nettype none
module pwrsw_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hard_powerdown_n,
  input wire logic por_ok,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic secure_sig_in,
  input wire logic aux_port_pin,
  input wire logic secure_sig_int,
  input wire logic aux_port_int,
  input wire logic secure_supply_en,
  input wire logic inrush_limit_en,
  input wire logic current_sources_en,
  input wire logic irq
);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pads pass through two sync flops, so the view lags the pad by two edges
  a_sig_view_pad: assert property (secure_sig_int |-> $past(secure_sig_in, 2))
    else $error("secure input view high while pad was low");
  a_aux_view_pad: assert property (!aux_port_int |-> !$past(aux_port_pin, 2))
    else $error("aux view low while pad was high");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read taken without answer next cycle");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while answer pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write taken without response two cycles later");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before taken");
  // Margin of a few cycles covers the pin synchroniser and one register stage
  a_hpd_cuts_all: assert property (!hard_powerdown_n [*5] |-> !current_sources_en
      && !secure_supply_en && inrush_limit_en && !irq)
    else $error("hard power-down did not hold the block in reset");
  a_por_holds_reset: assert property (!por_ok [*5] |-> !s_axi_bvalid && !s_axi_rvalid
      && !secure_supply_en && !irq)
    else $error("low supply did not hold the block in reset");
endmodule
`default_nettype wire

// ### test/tb_power_switch_rng_control.sv
// Self-checking bench for the power switch and random control block
`timescale 1ns/1ns
`default_nettype none
`include "pwrsw_regs.svh"
module tb_power_switch_rng_control;
  // ----------------------------------------------------------------------
  // Signals, clock and timeout
  // ----------------------------------------------------------------------
  localparam logic [`PWRSW_ADDR_W-1:0] ad_rnd = {`PWRSW_IDX_RANDOM_VALUE, 2'b00};
  localparam logic [`PWRSW_ADDR_W-1:0] ad_ctl = {`PWRSW_IDX_SWITCH_CTRL, 2'b00};
  localparam logic [`PWRSW_ADDR_W-1:0] ad_sts = {`PWRSW_IDX_IRQ_STATUS, 2'b00};
  localparam logic [`PWRSW_ADDR_W-1:0] ad_msk = {`PWRSW_IDX_IRQ_MASK, 2'b00};
  localparam logic [`PWRSW_ADDR_W-1:0] ad_pwr = {`PWRSW_IDX_POWER_CTRL, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0, hard_powerdown_n = 1'b1, por_ok = 1'b1;
  logic [`PWRSW_ADDR_W-1:0] s_axi_awaddr = 18'h0_0000, s_axi_araddr = 18'h0_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, secure_sig_in = 1'b1, aux_port_pin = 1'b0;
  logic limiter_active = 1'b0, contactless_rng_run = 1'b0, wake_event = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic secure_sig_int, aux_port_int, secure_supply_en, inrush_limit_en;
  logic current_sources_en, core_idle, irq;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  pwrsw_top i_dut (.aclk, .aresetn, .hard_powerdown_n, .por_ok, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .secure_sig_in, .aux_port_pin, .limiter_active,
    .contactless_rng_run, .wake_event, .secure_sig_int, .aux_port_int, .secure_supply_en,
    .inrush_limit_en, .current_sources_en, .core_idle, .irq);

  always #5 aclk = ~aclk;

  // A generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cv(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cb(input logic got, input logic exp);
    cv(32'(got), 32'(exp));
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        cv(32'(s_axi_bresp), 32'(er));
        break;
      end
    end
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        cv(s_axi_rdata & m, e);
        cv(32'(s_axi_rresp), 32'(er));
        break;
      end
    end
  endtask

  task automatic ww(input logic [17:0] a, input logic [7:0] d);
    wr(a, d, 2'b00);
  endtask

  task automatic rr(input logic [17:0] a, input logic [31:0] e);
    rd(a, 32'hffff_ffff, e, 2'b00);
  endtask

  task automatic idle_is(input logic v);
    int n;
    for (n = 0; n < 20 && core_idle !== v; n++) @(posedge aclk);
    cb(core_idle, v);
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Local reset lags the bus reset by the two pin synchroniser stages
    repeat (2) @(posedge aclk);
    rr(ad_ctl, 32'h0000_0041);
    cb(secure_supply_en, 1'b0);
    cb(inrush_limit_en, 1'b1);
    cb(secure_sig_int, 1'b0);
    cb(aux_port_int, 1'b1);
    $display("reset values done");
    ww(ad_ctl, 8'hb9);
    rr(ad_ctl, 32'h0000_0019);
    cb(secure_supply_en, 1'b1);
    cb(inrush_limit_en, 1'b0);
    cb(secure_sig_int, 1'b1);
    cb(aux_port_int, 1'b0);
    secure_sig_in <= 1'b0;
    aux_port_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    cb(secure_sig_int, 1'b0);
    cb(aux_port_int, 1'b1);
    ww(ad_ctl, 8'h40);
    secure_sig_in <= 1'b1;
    aux_port_pin <= 1'b0;
    rr(ad_ctl, 32'h0000_0041);
    cb(secure_supply_en, 1'b0);
    cb(secure_sig_int, 1'b0);
    cb(aux_port_int, 1'b1);
    $display("control writes done");
    limiter_active <= 1'b1;
    repeat (4) @(posedge aclk);
    rr(ad_ctl, 32'h0000_0061);
    limiter_active <= 1'b0;
    repeat (4) @(posedge aclk);
    rr(ad_ctl, 32'h0000_0041);
    ww(ad_msk, 8'h02);
    cb(irq, 1'b1);
    ww(ad_msk, 8'h00);
    cb(irq, 1'b0);
    ww(ad_sts, 8'h02);
    ww(ad_msk, 8'h02);
    cb(irq, 1'b0);
    rr(ad_sts, 32'h0000_0000);
    $display("overload and interrupt done");
    contactless_rng_run <= 1'b1;
    repeat (20) @(posedge aclk);
    contactless_rng_run <= 1'b0;
    rr(ad_ctl, 32'h0000_0043);
    rd(ad_rnd, 32'hffff_ff00, 32'h0000_0000, 2'b00);
    rr(ad_ctl, 32'h0000_0041);
    ww(ad_ctl, 8'h44);
    repeat (20) @(posedge aclk);
    rr(ad_ctl, 32'h0000_0047);
    ww(ad_ctl, 8'h40);
    // A value may still land as the generator stops, so clear ready once more
    ww(ad_ctl, 8'h40);
    rr(ad_ctl, 32'h0000_0041);
    rd(18'h0_0000, 32'hffff_ffff, 32'h0000_0000, 2'b10);
    wr(18'h0_0000, 8'h00, 2'b10);
    $display("random and unmapped done");
    ww(ad_pwr, 8'h03);
    idle_is(1'b1);
    wake_event <= 1'b1;
    idle_is(1'b0);
    wake_event <= 1'b0;
    $display("soft power-down done");
    // Both reset pins walk the same sequence; only hard power-down cuts the sources
    for (int k = 0; k < 2; k++) begin
      ww(ad_ctl, 8'h18);
      if (k == 0) hard_powerdown_n <= 1'b0;
      else por_ok <= 1'b0;
      repeat (6) @(posedge aclk);
      cb(secure_supply_en, 1'b0);
      cb(current_sources_en, k[0]);
      hard_powerdown_n <= 1'b1;
      por_ok <= 1'b1;
      repeat (6) @(posedge aclk);
      rr(ad_ctl, 32'h0000_0041);
    end
    $display("pin resets done");
    stop_test();
  end
endmodule

bind pwrsw_top pwrsw_assertions i_chk (.aclk, .aresetn, .hard_powerdown_n, .por_ok,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .secure_sig_in, .aux_port_pin, .secure_sig_int, .aux_port_int,
  .secure_supply_en, .inrush_limit_en, .current_sources_en, .irq);
`default_nettype wire
